//--- hw/asfr_ctrl.sv
// asfr_ctrl: timing controller for the sensor readout, with its capture FIFO.
// assumes the sensor end shares i_clk; the user drains pixels by valid/ready.
`timescale 1ns/10ps
module asfr_fifo #(
  parameter int W = 24,
  parameter int D = 16
)(
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic [W-1:0]      o_data,
  output logic              o_empty
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  cnt_q;
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;

  wire push = i_valid && o_ready;
  wire pop  = o_valid && i_ready;

  // storage and pointers; pointers wrap at D-1, for any depth
  always_ff @(posedge i_clk) begin
    if (push) mem[wr_q] <= i_data;
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
      if (pop)  rd_q <= (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  assign o_ready = (cnt_q != (AW+1)'(D));
  assign o_valid = (cnt_q != '0);
  assign o_empty = (cnt_q == '0);
  assign o_data  = mem[rd_q];
endmodule : asfr_fifo

module asfr_ctrl
  import asfr_pkg::*;
#(
  parameter int DW         = 12,
  parameter int FIFO_DEPTH = 16,
  parameter int IMAX       = INTEG_MAX_MCLK      // longest integration, master clocks
)(
  // clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rst_b,
  // link to the sensor
  asfr_link_if.ctl           link,
  // frame command
  input  wire logic          i_start,
  input  wire logic          i_continuous,
  input  wire logic [16:0]   i_integ_mclk,
  // pixel stream out
  output logic               o_px_valid,
  input  wire logic          i_px_ready,
  output logic [DW-1:0]      o_px_data,
  output logic [5:0]         o_px_row,
  output logic [5:0]         o_px_col,
  // status
  output logic               o_busy,
  output logic               o_overflow
);

  // ---------------------------------------------------------------------------
  // master clock divider
  // ---------------------------------------------------------------------------
  logic [7:0] div_q;
  logic       tick_q;
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      div_q  <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      div_q  <= (div_q == 8'(MCLK_DIV - 1)) ? 8'h00 : div_q + 8'h01;
      tick_q <= (div_q == 8'(MCLK_DIV - 1));
    end
  end

  // ---------------------------------------------------------------------------
  // frame start pulse sequencer
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    CS_IDLE  = 2'h0,
    CS_INTEG = 2'h1,
    CS_SCAN  = 2'h2
  } asfr_cstate_t;

  asfr_cstate_t cst_q;
  logic [16:0]  len_q;
  logic [16:0]  cnt_q;
  logic [12:0]  npix_q;
  logic         fs_q;
  logic         strobe_prev_q;
  logic         ovf_q;
  logic [5:0]   row_q;
  logic [5:0]   col_q;
  logic         fifo_ready;
  logic         fifo_empty;

  // integration length forced into the legal window of the sensor
  wire [16:0] want    = i_integ_mclk;
  wire [16:0] integ_n = (want < 17'(INTEG_MIN)) ? 17'(INTEG_MIN) :
                        (want > 17'(IMAX)) ? 17'(IMAX) : want;
  // a new frame waits for an empty FIFO, so a slow reader stalls the sensor
  wire go        = (i_start || i_continuous) && fifo_empty;
  wire all_pix   = (npix_q == 13'(FRAME_PIX));
  wire scan_done = all_pix && (cnt_q >= 17'(RESET_MIN - 1));
  wire strobe_up = link.conversion_strobe && !strobe_prev_q;

  // transitions change only on the clock between master ticks, never with one
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cst_q <= CS_IDLE;
      fs_q  <= FS_RESET_LEVEL;
      cnt_q <= 17'h00000;
      len_q <= 17'h00000;
    end else if (div_q == 8'(MCLK_DIV / 2)) begin
      unique case (cst_q)
        CS_IDLE: if (go) begin
          cst_q <= CS_INTEG;
          fs_q  <= 1'b0;
          len_q <= integ_n;
          cnt_q <= 17'h00000;
        end
        CS_INTEG: begin
          cnt_q <= cnt_q + 17'h00001;
          if (cnt_q == len_q - 17'h00001) begin
            cst_q <= CS_SCAN;
            fs_q  <= 1'b1;
            cnt_q <= 17'h00000;
          end
        end
        CS_SCAN: begin
          if (cnt_q != 17'h1ffff) cnt_q <= cnt_q + 17'h00001;
          if (scan_done) cst_q <= CS_IDLE;
        end
        default: cst_q <= CS_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // capture: one sample per strobe, position counted here
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      strobe_prev_q <= 1'b0;
      npix_q        <= 13'h0000;
      row_q         <= 6'h00;
      col_q         <= 6'h00;
      ovf_q         <= 1'b0;
    end else begin
      strobe_prev_q <= link.conversion_strobe;
      if (cst_q == CS_INTEG) begin
        npix_q <= 13'h0000;
        row_q  <= 6'h00;
        col_q  <= 6'h00;
      end else if (strobe_up && (cst_q == CS_SCAN) && !all_pix) begin
        npix_q <= npix_q + 13'h0001;
        col_q  <= col_q + 6'h01;
        if (col_q == 6'(COLS - 1)) row_q <= row_q + 6'h01;
        if (!fifo_ready) ovf_q <= 1'b1;
      end
      if (go && (cst_q == CS_IDLE)) ovf_q <= 1'b0;
    end
  end

  wire [DW+11:0] fifo_out;
  asfr_fifo #(.W(DW + 12), .D(FIFO_DEPTH)) u_fifo (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_valid (strobe_up && (cst_q == CS_SCAN) && !all_pix),
    .o_ready (fifo_ready),
    .i_data  ({row_q, col_q, link.video}),
    .o_valid (o_px_valid),
    .i_ready (i_px_ready),
    .o_data  (fifo_out),
    .o_empty (fifo_empty)
  );

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign link.mclk_en           = tick_q;
  assign link.frame_start_pulse = fs_q;
  assign o_px_data  = fifo_out[DW-1:0];
  assign o_px_col   = fifo_out[DW+5:DW];
  assign o_px_row   = fifo_out[DW+11:DW+6];
  assign o_busy     = (cst_q != CS_IDLE);
  assign o_overflow = ovf_q;

endmodule : asfr_ctrl

//--- hw/asfr_link_if.sv
// asfr_link_if: the wires between the sensor readout and its timing controller.
// assumes both ends run on the same clock; the controller owns mclk_en.
`timescale 1ns/10ps
interface asfr_link_if #(
  parameter int DW = 12
);
  logic          mclk_en;            // master clock tick, one clk wide
  logic          frame_start_pulse;  // low: integrate, high: frame scan
  logic [DW-1:0] video;              // offset-compensated pixel value
  logic          conversion_strobe;  // converter sample point

  modport dev (input mclk_en, input frame_start_pulse, output video, output conversion_strobe);
  modport ctl (output mclk_en, output frame_start_pulse, input video, input conversion_strobe);
endinterface : asfr_link_if

//--- hw/asfr_pkg.sv
// asfr_pkg: shared constants for the area sensor frame readout pair.
// assumes one 100 MHz clock; the master clock of the sensor is an enable pulse.
package asfr_pkg;

  // ---------------------------------------------------------------------------
  // clock and divider
  // ---------------------------------------------------------------------------
  localparam int CLK_MHZ      = 100;                 // system clock rate in MHz
  localparam int MCLK_DIV     = 3;                   // clocks per master clock (33.3 MHz, under 40 MHz)

  // ---------------------------------------------------------------------------
  // array geometry and pixel timing, in master clocks
  // ---------------------------------------------------------------------------
  localparam int ROWS         = 64;
  localparam int COLS         = 64;
  localparam int PIX_MCLK     = 8;                   // master clocks per pixel output
  localparam int ROW_BLANK    = 94;                  // blank master clocks between rows
  localparam int INTEG_MIN    = 40;                  // least integration, master clocks
  localparam int RESET_MIN    = 200;                 // least reset (high) period, master clocks
  localparam int INTEG_MAX_US = 2000;                // longest integration in us
  localparam int INTEG_MAX_MCLK = INTEG_MAX_US * CLK_MHZ / MCLK_DIV;  // rounds down
  localparam int FRAME_PIX    = ROWS * COLS;         // 4096 outputs per frame

  // ---------------------------------------------------------------------------
  // phase points inside one pixel slot
  // ---------------------------------------------------------------------------
  localparam logic [2:0] PH_SIG_LATCH = 3'h1;        // held signal level captured
  localparam logic [2:0] PH_RST_BEGIN = 3'h2;        // amplifier reset, reset level selected
  localparam logic [2:0] PH_RST_LATCH = 3'h3;        // reset level captured
  localparam logic [2:0] PH_DIFF      = 3'h4;        // difference driven onto the video
  localparam logic [2:0] PH_LAST      = 3'h7;

  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic FS_RESET_LEVEL = 1'b1;            // start pulse parked high when idle

endpackage : asfr_pkg

//--- hw/asfr_sensor.sv
// asfr_sensor: timing generator of a 64x64 global-shutter sensor readout.
// assumes the pixel array model answers i_level for o_row/o_col/o_level_sel
// in the same clock, and that the controller keeps its timing limits.
`timescale 1ns/10ps
module asfr_sensor
  import asfr_pkg::*;
#(
  parameter int DW = 12
)(
  // clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rst_b,
  // link to the timing controller
  asfr_link_if.dev           link,
  // pixel array side
  output logic [5:0]         o_row,
  output logic [5:0]         o_col,
  output logic               o_level_sel,
  output logic               o_amp_reset,
  input  wire logic [DW-1:0] i_level,
  // status
  output logic               o_integrating,
  output logic               o_hold,
  output logic               o_frame_done
);

  // ---------------------------------------------------------------------------
  // states
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_WAIT  = 3'h0,   // after reset: wait for a low start pulse
    ST_INTEG = 3'h1,   // integrating, all pixels sampled together
    ST_READ  = 3'h2,   // pixel slots of the selected row
    ST_BLANK = 3'h3,   // blank between rows
    ST_DONE  = 3'h4    // last row read, waiting for the falling start pulse
  } asfr_state_t;

  asfr_state_t   state_q;
  logic [5:0]    row_q;
  logic [5:0]    col_q;
  logic [2:0]    ph_q;
  logic [6:0]    blank_q;
  logic [DW-1:0] sig_q;
  logic [DW-1:0] rst_q;
  logic [DW-1:0] video_q;
  logic          strobe_q;
  logic          lvl_sel_q;
  logic          amp_rst_q;
  logic          integ_q;
  logic          hold_q;
  logic          done_q;

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  // clamps at zero: a reset level above the signal is noise, not a negative charge
  function automatic logic [DW-1:0] asfr_diff(input logic [DW-1:0] s, input logic [DW-1:0] r);
    asfr_diff = (s > r) ? DW'(s - r) : '0;
  endfunction : asfr_diff

  // decode of the slot and frame position, all evaluated at a master tick
  wire tick      = link.mclk_en;
  wire fs        = link.frame_start_pulse;
  wire slot_end  = (ph_q == PH_LAST);
  wire row_end   = slot_end && (col_q == 6'(COLS - 1));
  wire frame_end = row_end && (row_q == 6'(ROWS - 1));
  wire blank_end = (blank_q == 7'(ROW_BLANK - 1));
  wire scan_go   = (state_q == ST_INTEG) && fs;
  wire scan_abort = ((state_q == ST_READ) || (state_q == ST_BLANK)) && !fs;
  wire [DW-1:0] diff = asfr_diff(sig_q, rst_q);

  // ---------------------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------------------
  // every step waits for a master tick, the stand-in for its falling edge
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      state_q <= ST_WAIT;
    end else if (tick) begin
      unique case (state_q)
        ST_WAIT:  if (!fs) state_q <= ST_INTEG;
        ST_INTEG: if (fs) state_q <= ST_READ;
        // a start pulse dropped mid-scan abandons the frame rather than finish it
        ST_READ: begin
          if (scan_abort) state_q <= ST_INTEG;
          else if (frame_end) state_q <= ST_DONE;
          else if (row_end) state_q <= ST_BLANK;
        end
        ST_BLANK: begin
          if (scan_abort) state_q <= ST_INTEG;
          else if (blank_end) state_q <= ST_READ;
        end
        ST_DONE:  if (!fs) state_q <= ST_INTEG;
        default:  state_q <= ST_WAIT;
      endcase
    end
  end

  // position counters: row then column, upper left first
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      row_q <= 6'h00;
      col_q <= 6'h00;
      ph_q  <= 3'h0;
    end else if (tick) begin
      if (scan_go) begin
        row_q <= 6'h00;
        col_q <= 6'h00;
        ph_q  <= 3'h0;
      end else if (state_q == ST_READ) begin
        ph_q <= ph_q + 3'h1;
        if (slot_end) col_q <= col_q + 6'h01;
      end else if ((state_q == ST_BLANK) && blank_end) begin
        row_q <= row_q + 6'h01;
        col_q <= 6'h00;
        ph_q  <= 3'h0;
      end
    end
  end

  // row blank counter; no video change and no strobe while it runs
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      blank_q <= 7'h00;
    end else if (tick) begin
      blank_q <= (state_q == ST_BLANK) ? blank_q + 7'h01 : 7'h00;
    end
  end

  // ---------------------------------------------------------------------------
  // pixel levels and offset compensation
  // ---------------------------------------------------------------------------
  // the reset level is taken after the signal so one amplifier offset cancels
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      sig_q     <= '0;
      rst_q     <= '0;
      lvl_sel_q <= 1'b0;
      amp_rst_q <= 1'b0;
    end else if (tick && (state_q == ST_READ)) begin
      if (ph_q == PH_SIG_LATCH) sig_q <= i_level;
      if (ph_q == PH_RST_LATCH) rst_q <= i_level;
      lvl_sel_q <= (ph_q >= PH_SIG_LATCH) && (ph_q < PH_RST_LATCH);
      amp_rst_q <= (ph_q == PH_SIG_LATCH);
    end else if (tick) begin
      lvl_sel_q <= 1'b0;
      amp_rst_q <= 1'b0;
    end
  end

  // video holds its value across the blank; the strobe marks each new one
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      video_q  <= '0;
      strobe_q <= 1'b0;
    end else if (tick) begin
      if ((state_q == ST_READ) && (ph_q == PH_DIFF)) video_q <= diff;
      strobe_q <= (state_q == ST_READ) && (ph_q == PH_DIFF);
    end
  end

  // ---------------------------------------------------------------------------
  // shutter and status
  // ---------------------------------------------------------------------------
  // hold is a one-clock pulse: all pixels freeze together at the rise
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      integ_q <= 1'b0;
      hold_q  <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      hold_q <= tick && scan_go;
      if (tick) begin
        integ_q <= !fs;
        if (frame_end && (state_q == ST_READ) && fs) done_q <= 1'b1;
        else if (!fs) done_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign link.video             = video_q;
  assign link.conversion_strobe = strobe_q;
  assign o_row         = row_q;
  assign o_col         = col_q;
  assign o_level_sel   = lvl_sel_q;
  assign o_amp_reset   = amp_rst_q;
  assign o_integrating = integ_q;
  assign o_hold        = hold_q;
  assign o_frame_done  = done_q;

endmodule : asfr_sensor

//--- sim/asfr_properties.sv
// asfr_properties: timing checks on the link between sensor and controller.
// assumes one clock domain; instantiated beside the link in tb_top.
`timescale 1ns/10ps
module asfr_properties
  import asfr_pkg::*;
#(
  parameter int DW   = 12,
  parameter int IMAX = INTEG_MAX_MCLK
)(
  input wire logic          i_clk,
  input wire logic          i_rst_b,
  input wire logic          mclk_en,
  input wire logic          frame_start_pulse,
  input wire logic [DW-1:0] video,
  input wire logic          conversion_strobe
);
  // ---------------------------------------------------------------------------
  // helper counters
  // ---------------------------------------------------------------------------
  logic [11:0] gap_q;   // clocks since last strobe rise
  logic [12:0] n_q;     // strobes since scan began
  logic [19:0] run_q;   // clocks since last start pulse edge
  logic        scan_q;  // a scan began since reset
  logic        cs_q;
  logic        fs_q;
  wire         cs_rise = conversion_strobe & ~cs_q;
  wire         fs_edge = frame_start_pulse ^ fs_q;

  // clock counters gap_q and run_q saturate so a long idle cannot wrap into a legal value
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      gap_q  <= 12'h000;
      n_q    <= 13'h0000;
      run_q  <= 20'h00000;
      scan_q <= 1'b0;
      cs_q   <= 1'b0;
      fs_q   <= 1'b1;
    end else begin
      gap_q  <= cs_rise ? 12'h001 : ((gap_q == 12'hfff) ? gap_q : gap_q + 12'h001);
      n_q    <= frame_start_pulse ? n_q + {12'h000, cs_rise} : 13'h0000;
      run_q  <= fs_edge ? 20'h00001 : ((run_q == 20'hfffff) ? run_q : run_q + 20'h00001);
      scan_q <= scan_q | (fs_edge & frame_start_pulse);
      cs_q   <= conversion_strobe;
      fs_q   <= frame_start_pulse;
    end
  end

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  mclk_period_a: assert property (mclk_en |=> !mclk_en [*2] ##1 mclk_en)
    else $error("master tick spacing wrong");
  strobe_width_a: assert property ($rose(conversion_strobe) |-> conversion_strobe [*3] ##1 !conversion_strobe)
    else $error("strobe width wrong");
  strobe_tick_a: assert property ($changed(conversion_strobe) |-> $past(mclk_en))
    else $error("strobe moved off a master tick");
  pixel_gap_a: assert property (cs_rise && n_q != 13'h0000 |-> gap_q == ((n_q[5:0] == 6'h00) ?
    12'((PIX_MCLK + ROW_BLANK) * MCLK_DIV) : 12'(PIX_MCLK * MCLK_DIV)))
    else $error("pixel or row spacing wrong");
  frame_count_a: assert property (cs_rise |-> n_q < 13'h1000)
    else $error("too many pixels in a frame");
  integ_quiet_a: assert property (!frame_start_pulse |-> !$rose(conversion_strobe))
    else $error("strobe while integrating");
  scan_start_a: assert property ($rose(frame_start_pulse) |-> ##[4:60] $rose(conversion_strobe))
    else $error("scan did not start");
  video_hold_a: assert property (frame_start_pulse && n_q != 13'h0000 && $changed(video) |-> cs_rise)
    else $error("video changed between pixels");
  integ_min_a: assert property ($rose(frame_start_pulse) |-> run_q >= INTEG_MIN * MCLK_DIV)
    else $error("integration too short");
  integ_max_a: assert property ($rose(frame_start_pulse) |-> run_q <= IMAX * MCLK_DIV)
    else $error("integration too long");
  reset_min_a: assert property ($fell(frame_start_pulse) && scan_q |-> run_q >= RESET_MIN * MCLK_DIV)
    else $error("reset period too short");
  fs_clear_a: assert property ($changed(frame_start_pulse) |-> !mclk_en && !$past(mclk_en))
    else $error("start pulse moved on a master tick");
endmodule : asfr_properties

//--- sim/tb_top.sv
// tb_top: both readout ends joined by the link; the pixel array is modelled here.
// assumes 100 MHz; one full frame plus a stalled partial one, about 117k clocks.
`timescale 1ns/10ps
module tb_top;
  import asfr_pkg::*;
  logic        i_clk;
  logic        i_rst_b;
  logic        i_start;
  logic        i_continuous;
  logic [16:0] i_integ_mclk;
  logic        i_px_ready;
  logic        o_px_valid;
  logic [11:0] o_px_data;
  logic [5:0]  o_px_row;
  logic [5:0]  o_px_col;
  logic        o_busy;
  logic        o_overflow;
  logic [5:0]  row;
  logic [5:0]  col;
  logic        lsel;
  logic        amp_rst;
  logic        integ;
  logic        hold;
  logic        done;
  logic [11:0] lvl;
  int          n_errors = 0;
  int          comparisons = 0;
  int          n_hold = 0;
  int          n_amp = 0;

  // ---------------------------------------------------------------------------
  // pixel array: signal is the position, reset level a fixed 5, so the first
  // five pixels also exercise the clamp at zero
  // ---------------------------------------------------------------------------
  assign lvl = lsel ? 12'h005 : {row, col};

  asfr_link_if link ();
  asfr_sensor u_asfr_sensor (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .link(link), .o_row(row), .o_col(col),
    .o_level_sel(lsel), .o_amp_reset(amp_rst), .i_level(lvl),
    .o_integrating(integ), .o_hold(hold), .o_frame_done(done));
  asfr_ctrl #(.DW(12), .IMAX(100)) u_asfr_ctrl (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .link(link), .i_start(i_start),
    .i_continuous(i_continuous), .i_integ_mclk(i_integ_mclk),
    .o_px_valid(o_px_valid), .i_px_ready(i_px_ready), .o_px_data(o_px_data),
    .o_px_row(o_px_row), .o_px_col(o_px_col), .o_busy(o_busy), .o_overflow(o_overflow));
  asfr_properties #(.IMAX(100)) u_asfr_properties (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .mclk_en(link.mclk_en),
    .frame_start_pulse(link.frame_start_pulse), .video(link.video),
    .conversion_strobe(link.conversion_strobe));

  // clock and hold-pulse monitor
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) if (i_rst_b === 1'b1 && hold === 1'b1) n_hold++;
  // amplifier reset clocks: one master period per pixel
  always @(posedge i_clk) if (i_rst_b === 1'b1 && amp_rst === 1'b1) n_amp++;

  // ---------------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------------
  task automatic check(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic reset_state;
    check(link.frame_start_pulse === 1'b1 && link.mclk_en === 1'b0 && link.conversion_strobe === 1'b0, "link reset");
    check(link.video === 12'h000 && o_busy === 1'b0 && o_overflow === 1'b0, "status reset");
  endtask : reset_state

  // holds the request until the start pulse drops, then times the low phase
  task automatic start_frame(input logic [16:0] len, input int exp_lo);
    int   n;
    logic seen;
    n = 0;
    seen = 1'b0;
    i_integ_mclk = len;
    i_start = 1'b1;
    while (link.frame_start_pulse !== 1'b0 && n < 100) begin
      @(negedge i_clk);
      n++;
    end
    i_start = 1'b0;
    n = 0;
    while (link.frame_start_pulse === 1'b0 && n < 5000) begin
      @(negedge i_clk);
      n++;
      if (n == 20) seen = integ;
    end
    check(n == exp_lo, "integration length");
    check(seen === 1'b1, "not integrating while start low");
    check(done === 1'b0, "frame done kept into new frame");
  endtask : start_frame

  // ready is left as the caller set it; one word is taken per call, once valid is seen
  task automatic take(input int k);
    int          w;
    logic [11:0] exp;
    w = 0;
    exp = (k[11:0] >= 12'h005) ? k[11:0] - 12'h005 : 12'h000;
    while (o_px_valid !== 1'b1 && w < 2000) begin
      @(negedge i_clk);
      w++;
    end
    check(o_px_row === k[11:6] && o_px_col === k[5:0], "pixel position");
    check(o_px_data === exp, "pixel value");
    @(negedge i_clk);
  endtask : take

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    int w;
    i_rst_b = 1'b0;
    i_start = 1'b0;
    i_continuous = 1'b0;
    i_integ_mclk = 17'h00032;
    i_px_ready = 1'b1;
    repeat (2) @(negedge i_clk);
    reset_state();
    i_rst_b = 1'b1;
    @(negedge i_clk);
    start_frame(17'h00032, 50 * MCLK_DIV);
    for (int k = 0; k < FRAME_PIX; k++) begin
      if (k % 1024 == 512) begin
        i_px_ready = 1'b0;
        repeat (300) @(negedge i_clk);
        i_px_ready = 1'b1;
      end
      i_start = (k == 100);
      if (k == 101) check(link.frame_start_pulse === 1'b1 && o_busy === 1'b1, "start taken mid-scan");
      take(k);
    end
    w = 0;
    // the controller goes idle a few clocks before the sensor marks its last row
    while ((o_busy !== 1'b0 || done !== 1'b1) && w < 5000) begin
      @(negedge i_clk);
      w++;
    end
    check(done === 1'b1 && link.frame_start_pulse === 1'b1, "frame end state");
    check(n_hold == 1 && o_overflow === 1'b0, "hold count or false overflow");
    check(n_amp == FRAME_PIX * MCLK_DIV, "amplifier reset count");
    // second frame: short length is clamped, stalled consumer overflows
    i_px_ready = 1'b0;
    i_continuous = 1'b1;
    start_frame(17'h0000a, INTEG_MIN * MCLK_DIV);
    w = 0;
    while (o_overflow !== 1'b1 && w < 3000) begin
      @(negedge i_clk);
      w++;
    end
    check(o_overflow === 1'b1, "no overflow with consumer stalled");
    i_px_ready = 1'b1;
    for (int k = 0; k < 16; k++) take(k);
    take(17);
    check(o_px_valid === 1'b0, "buffer not empty after drain");
    i_rst_b = 1'b0;
    repeat (2) @(negedge i_clk);
    reset_state();
    report_and_stop();
  end

  // watchdog, sized for one frame and a part
  initial begin
    repeat (150000) @(posedge i_clk);
    check(1'b0, "watchdog expired");
    report_and_stop();
  end
endmodule : tb_top
